// ===== src/dcs_pkg.sv
`default_nettype none

package dcs_pkg;

  localparam int MEM_CLK_MHZ = 100;
  localparam int DATA_W = 32;
  localparam int BURST_W = 64;
  localparam int ADDR_W = 22;
  localparam int MA_W = 12;
  localparam int FIFO_DEPTH = 4;

  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam int REFRESH_TICKS = (REFRESH_INTERVAL_NS * MEM_CLK_MHZ) / 1000;
  localparam int POWERUP_US = 200;
  localparam int POWERUP_TICKS = POWERUP_US * MEM_CLK_MHZ;
  localparam int INIT_REFRESHES = 8;
  localparam int REFRESH_GAP_TICKS = 8;
  localparam int WRITE_RECOVERY_TICKS = 2;
  localparam int MODE_GAP_TICKS = 2;

  typedef logic [15:0] dcs_cnt_type;
  localparam dcs_cnt_type TIMING_FAST = 16'h0002;
  localparam dcs_cnt_type TIMING_SLOW = 16'h0003;

  localparam int PRECHARGE_ALL_BIT = 10;
  localparam logic [2:0] BURST_LEN_TWO = 3'h1;
  localparam logic WRAP_SEQUENTIAL = 1'h0;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } dcs_cmd_type;

  localparam dcs_cmd_type CMD_NOP = 4'h7;
  localparam dcs_cmd_type CMD_ACTIVATE = 4'h3;
  localparam dcs_cmd_type CMD_READ = 4'h5;
  localparam dcs_cmd_type CMD_WRITE = 4'h4;
  localparam dcs_cmd_type CMD_PRECHARGE = 4'h2;
  localparam dcs_cmd_type CMD_REFRESH = 4'h1;
  localparam dcs_cmd_type CMD_MODE = 4'h0;

  typedef enum logic [10:0] {
    ST_INIT_WAIT = 11'h001,
    ST_INIT_PRE = 11'h002,
    ST_INIT_REF = 11'h004,
    ST_INIT_MODE = 11'h008,
    ST_IDLE = 11'h010,
    ST_ACTIVATE = 11'h020,
    ST_XFER = 11'h040,
    ST_RECOVER = 11'h080,
    ST_PRECHARGE = 11'h100,
    ST_REFRESH = 11'h200,
    ST_PUSH = 11'h400
  } dcs_state_type;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BURST_W-1:0] data;
    logic [7:0] mask;
  } dcs_req_type;

  typedef struct packed {
    logic rasPrecharge3;
    logic rasToCas3;
    logic casLatency3;
    logic [1:0] waitStates;
  } dcs_cfg_type;

endpackage

`default_nettype wire

// ===== src/dcs_async_fifo.sv
`default_nettype none

module dcs_async_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic wrClk,
  input wire logic wrResetN,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdClk,
  input wire logic rdResetN,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic notFull;
    logic [AW:0] rdGray1;
    logic [AW:0] rdGray2;
  } dcs_fifo_wr_type;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic outValid;
    logic [WIDTH-1:0] outData;
    logic [AW:0] wrGray1;
    logic [AW:0] wrGray2;
  } dcs_fifo_rd_type;

  dcs_fifo_wr_type w, next_w;
  dcs_fifo_rd_type r, next_r;

  function automatic logic [AW:0] binToGray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Room is registered so that the filling side sees a clean flop output.
  always_comb begin
    logic [AW:0] nb;
    nb = w.bin;
    next_w = w;
    next_w.rdGray1 = r.gray;
    next_w.rdGray2 = w.rdGray1;
    if (wrValid && w.notFull) begin
      next_w.mem[w.bin[AW-1:0]] = wrData;
      nb = w.bin + {{AW{1'b0}}, 1'b1};
    end
    next_w.bin = nb;
    next_w.gray = binToGray(nb);
    next_w.notFull = (binToGray(nb) != {~w.rdGray2[AW:AW-1], w.rdGray2[AW-2:0]});
  end

  always_ff @(posedge wrClk) begin
    if (!wrResetN) begin
      w <= '0;
      w.notFull <= 1'b1;
    end else begin
      w <= next_w;
    end
  end

  // The head word is moved into an output register, so data leave from a flop.
  always_comb begin
    logic empty;
    logic load;
    empty = (r.gray == r.wrGray2);
    load = !empty && (!r.outValid || rdReady);
    next_r = r;
    next_r.wrGray1 = w.gray;
    next_r.wrGray2 = r.wrGray1;
    if (load) begin
      next_r.outData = w.mem[r.bin[AW-1:0]];
      next_r.outValid = 1'b1;
      next_r.bin = r.bin + {{AW{1'b0}}, 1'b1};
      next_r.gray = binToGray(next_r.bin);
    end else if (rdReady) begin
      next_r.outValid = 1'b0;
    end
  end

  always_ff @(posedge rdClk) begin
    if (!rdResetN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wrReady = w.notFull;
  assign rdValid = r.outValid;
  assign rdData = r.outData;

endmodule

`default_nettype wire

// ===== src/dcs_sdram_ctrl.sv
`default_nettype none

module dcs_sdram_ctrl #(
  parameter int POWERUP_TICKS = dcs_pkg::POWERUP_TICKS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic memClk,
  input wire logic reqValid,
  output logic reqReady,
  input wire dcs_pkg::dcs_req_type reqCmd,
  output logic rspValid,
  input wire logic rspReady,
  output logic [dcs_pkg::BURST_W-1:0] rspData,
  input wire dcs_pkg::dcs_cfg_type cfg,
  output logic dc_write_clock,
  output logic dc_read_clock,
  output logic dc_chip_select_n,
  output logic dc_row_strobe_n,
  output logic dc_col_strobe_n,
  output logic dc_write_enable_n,
  output logic [7:0] dc_byte_mask,
  output logic [dcs_pkg::MA_W-1:0] dc_addr_bus,
  output logic [dcs_pkg::DATA_W-1:0] dc_data_bus_out,
  output logic dc_data_bus_oe,
  input wire logic [dcs_pkg::DATA_W-1:0] dc_data_bus_in
);

  typedef struct packed {
    dcs_pkg::dcs_state_type state;
    dcs_pkg::dcs_cnt_type cnt;
    dcs_pkg::dcs_cnt_type refCnt;
    logic refDue;
    logic [3:0] initRefLeft;
    logic beat;
    logic clkPhase;
    logic readClock;
    logic cmdPop;
    logic rspPush;
    dcs_pkg::dcs_req_type req;
    logic [dcs_pkg::BURST_W-1:0] rdData;
    dcs_pkg::dcs_cmd_type cmd;
    logic [dcs_pkg::MA_W-1:0] addrBus;
    logic [7:0] mask;
    logic [dcs_pkg::DATA_W-1:0] dq;
    logic oe;
    dcs_pkg::dcs_cfg_type cfg1;
    dcs_pkg::dcs_cfg_type cfg2;
    logic [dcs_pkg::DATA_W-1:0] dqIn1;
    logic [dcs_pkg::DATA_W-1:0] dqIn2;
  } dcs_ctrl_type;

  dcs_ctrl_type s, next_s;
  logic [1:0] memRstSync;
  logic memRstN;
  logic cmdValid;
  dcs_pkg::dcs_req_type cmdData;
  logic rspWrReady;

  // Row phase: bank on line 11, then bits 11, 21, 20 and 19..12.
  function automatic logic [dcs_pkg::MA_W-1:0] rowAddr(input logic [dcs_pkg::ADDR_W-1:0] a);
    return {a[10], a[11], a[21], a[20], a[19:12]};
  endfunction

  // Column phase: bank on line 11, lines 10..8 unused and held low.
  function automatic logic [dcs_pkg::MA_W-1:0] colAddr(input logic [dcs_pkg::ADDR_W-1:0] a);
    return {a[10], 3'h0, a[9:2]};
  endfunction

  function automatic dcs_pkg::dcs_cnt_type ticksOf(input logic slow);
    return slow ? dcs_pkg::TIMING_SLOW : dcs_pkg::TIMING_FAST;
  endfunction

  // Mode word: burst of two, sequential wrap, latency two or three.
  function automatic logic [dcs_pkg::MA_W-1:0] modeWord(input logic slow);
    return {5'h00, slow ? 3'h3 : 3'h2, dcs_pkg::WRAP_SEQUENTIAL, dcs_pkg::BURST_LEN_TWO};
  endfunction

  // The memory-side reset is the core reset carried over into the link clock.
  always_ff @(posedge memClk) begin
    memRstSync <= {memRstSync[0], reset_n};
  end
  assign memRstN = memRstSync[1];

  // Requests cross into the link domain through a small gray-pointer FIFO.
  dcs_async_fifo #(
    .WIDTH($bits(dcs_pkg::dcs_req_type)),
    .DEPTH(dcs_pkg::FIFO_DEPTH)
  ) cmdFifo (
    .wrClk(sys_clk),
    .wrResetN(reset_n),
    .wrValid(reqValid),
    .wrReady(reqReady),
    .wrData(reqCmd),
    .rdClk(memClk),
    .rdResetN(memRstN),
    .rdValid(cmdValid),
    .rdReady(s.cmdPop),
    .rdData(cmdData)
  );

  dcs_async_fifo #(
    .WIDTH(dcs_pkg::BURST_W),
    .DEPTH(dcs_pkg::FIFO_DEPTH)
  ) rspFifo (
    .wrClk(memClk),
    .wrResetN(memRstN),
    .wrValid(s.rspPush),
    .wrReady(rspWrReady),
    .wrData(s.rdData),
    .rdClk(sys_clk),
    .rdResetN(reset_n),
    .rdValid(rspValid),
    .rdReady(rspReady),
    .rdData(rspData)
  );

  always_comb begin
    dcs_pkg::dcs_cnt_type waitTicks;
    logic refSet;
    logic refClr;
    waitTicks = dcs_pkg::dcs_cnt_type'(s.cfg2.waitStates);
    refSet = 1'b0;
    refClr = 1'b0;
    next_s = s;
    next_s.clkPhase = ~s.clkPhase;
    next_s.readClock = s.clkPhase;
    next_s.cfg1 = cfg;
    next_s.cfg2 = s.cfg1;
    next_s.dqIn1 = dc_data_bus_in;
    next_s.dqIn2 = s.dqIn1;
    next_s.cmdPop = 1'b0;
    next_s.rspPush = 1'b0;
    // Commands move only on the edge where the memory clock falls, so the
    // memory samples them half a period later with full margin.
    if (s.clkPhase) begin
      next_s.cmd = dcs_pkg::CMD_NOP;
      next_s.mask = 8'h00;
      next_s.oe = 1'b0;
      if (s.cnt != 16'h0000) begin
        next_s.cnt = s.cnt - 16'h0001;
      end
      if (s.refCnt == 16'h0000) begin
        next_s.refCnt = dcs_pkg::dcs_cnt_type'(dcs_pkg::REFRESH_TICKS - 1);
        refSet = 1'b1;
      end else begin
        next_s.refCnt = s.refCnt - 16'h0001;
      end
      case (s.state)
        dcs_pkg::ST_INIT_WAIT: begin
          if (s.cnt == 16'h0000) begin
            next_s.cmd = dcs_pkg::CMD_PRECHARGE;
            next_s.addrBus = 12'h000;
            next_s.addrBus[dcs_pkg::PRECHARGE_ALL_BIT] = 1'b1;
            next_s.cnt = ticksOf(s.cfg2.rasPrecharge3) - 16'h0001;
            next_s.state = dcs_pkg::ST_INIT_PRE;
          end
        end
        dcs_pkg::ST_INIT_PRE, dcs_pkg::ST_INIT_REF: begin
          if (s.cnt == 16'h0000) begin
            if (s.initRefLeft != 4'h0) begin
              next_s.cmd = dcs_pkg::CMD_REFRESH;
              next_s.initRefLeft = s.initRefLeft - 4'h1;
              next_s.cnt = dcs_pkg::dcs_cnt_type'(dcs_pkg::REFRESH_GAP_TICKS - 1);
              next_s.state = dcs_pkg::ST_INIT_REF;
            end else begin
              next_s.cmd = dcs_pkg::CMD_MODE;
              next_s.addrBus = modeWord(s.cfg2.casLatency3);
              next_s.cnt = dcs_pkg::dcs_cnt_type'(dcs_pkg::MODE_GAP_TICKS - 1);
              next_s.state = dcs_pkg::ST_INIT_MODE;
            end
          end
        end
        dcs_pkg::ST_INIT_MODE: begin
          if (s.cnt == 16'h0000) begin
            next_s.state = dcs_pkg::ST_IDLE;
          end
        end
        dcs_pkg::ST_IDLE: begin
          if (s.refDue) begin
            // A due refresh is served before any waiting access.
            next_s.cmd = dcs_pkg::CMD_REFRESH;
            refClr = 1'b1;
            next_s.cnt = dcs_pkg::dcs_cnt_type'(dcs_pkg::REFRESH_GAP_TICKS - 1);
            next_s.state = dcs_pkg::ST_REFRESH;
          end else if (cmdValid) begin
            // This port has no tie to system memory, so it never waits on it.
            next_s.req = cmdData;
            next_s.cmdPop = 1'b1;
            next_s.cmd = dcs_pkg::CMD_ACTIVATE;
            next_s.addrBus = rowAddr(cmdData.addr);
            next_s.cnt = ticksOf(s.cfg2.rasToCas3) - 16'h0001;
            next_s.state = dcs_pkg::ST_ACTIVATE;
          end
        end
        dcs_pkg::ST_ACTIVATE: begin
          if (s.cnt == 16'h0000) begin
            next_s.addrBus = colAddr(s.req.addr);
            next_s.beat = 1'b0;
            next_s.state = dcs_pkg::ST_XFER;
            if (s.req.write) begin
              next_s.cmd = dcs_pkg::CMD_WRITE;
              next_s.dq = s.req.data[31:0];
              next_s.mask = {s.req.mask[3:0], s.req.mask[3:0]};
              next_s.oe = 1'b1;
              next_s.cnt = 16'h0000;
            end else begin
              next_s.cmd = dcs_pkg::CMD_READ;
              next_s.cnt = ticksOf(s.cfg2.casLatency3);
            end
          end
        end
        dcs_pkg::ST_XFER: begin
          if (s.cnt == 16'h0000) begin
            if (s.req.write) begin
              // Second beat of the fixed two-word burst.
              next_s.dq = s.req.data[63:32];
              next_s.mask = {s.req.mask[7:4], s.req.mask[7:4]};
              next_s.oe = 1'b1;
              next_s.cnt = dcs_pkg::dcs_cnt_type'(dcs_pkg::WRITE_RECOVERY_TICKS - 1) +
                           waitTicks;
              next_s.state = dcs_pkg::ST_RECOVER;
            end else if (!s.beat) begin
              next_s.rdData[31:0] = s.dqIn2;
              next_s.beat = 1'b1;
            end else begin
              next_s.rdData[63:32] = s.dqIn2;
              next_s.cnt = waitTicks;
              next_s.state = dcs_pkg::ST_RECOVER;
            end
          end
        end
        dcs_pkg::ST_RECOVER: begin
          if (s.cnt == 16'h0000) begin
            next_s.cmd = dcs_pkg::CMD_PRECHARGE;
            next_s.addrBus = 12'h000;
            next_s.addrBus[dcs_pkg::PRECHARGE_ALL_BIT] = 1'b1;
            next_s.cnt = ticksOf(s.cfg2.rasPrecharge3) - 16'h0001;
            next_s.state = dcs_pkg::ST_PRECHARGE;
          end
        end
        dcs_pkg::ST_PRECHARGE: begin
          if (s.cnt == 16'h0000) begin
            next_s.state = s.req.write ? dcs_pkg::ST_IDLE : dcs_pkg::ST_PUSH;
          end
        end
        dcs_pkg::ST_REFRESH: begin
          if (s.cnt == 16'h0000) begin
            next_s.state = dcs_pkg::ST_IDLE;
          end
        end
        dcs_pkg::ST_PUSH: begin
          // Back-pressure from the response FIFO holds the channel here.
          if (rspWrReady) begin
            next_s.rspPush = 1'b1;
            next_s.state = dcs_pkg::ST_IDLE;
          end
        end
        default: begin
          next_s.state = dcs_pkg::ST_IDLE;
        end
      endcase
      // A refresh falling due in the same tick as a clear is kept.
      next_s.refDue = refSet | (s.refDue & ~refClr);
    end
  end

  always_ff @(posedge memClk) begin
    if (!memRstN) begin
      s <= '0;
      s.state <= dcs_pkg::ST_INIT_WAIT;
      s.cnt <= dcs_pkg::dcs_cnt_type'(POWERUP_TICKS - 1);
      s.refCnt <= dcs_pkg::dcs_cnt_type'(dcs_pkg::REFRESH_TICKS - 1);
      s.initRefLeft <= 4'(dcs_pkg::INIT_REFRESHES);
      s.readClock <= 1'b1;
      s.cmd <= dcs_pkg::CMD_NOP;
    end else begin
      s <= next_s;
    end
  end

  assign dc_write_clock = s.clkPhase;
  assign dc_read_clock = s.readClock;
  assign dc_chip_select_n = s.cmd.csN;
  assign dc_row_strobe_n = s.cmd.rasN;
  assign dc_col_strobe_n = s.cmd.casN;
  assign dc_write_enable_n = s.cmd.weN;
  assign dc_byte_mask = s.mask;
  assign dc_addr_bus = s.addrBus;
  assign dc_data_bus_out = s.dq;
  assign dc_data_bus_oe = s.oe;

  logic isAct;
  logic isRead;
  logic isWrite;
  logic isPre;
  logic isMode;
  logic initDone;
  assign isAct = (s.cmd == dcs_pkg::CMD_ACTIVATE);
  assign isRead = (s.cmd == dcs_pkg::CMD_READ);
  assign isWrite = (s.cmd == dcs_pkg::CMD_WRITE);
  assign isPre = (s.cmd == dcs_pkg::CMD_PRECHARGE);
  assign isMode = (s.cmd == dcs_pkg::CMD_MODE);
  assign initDone = !(s.state inside {dcs_pkg::ST_INIT_WAIT, dcs_pkg::ST_INIT_PRE,
                                      dcs_pkg::ST_INIT_REF, dcs_pkg::ST_INIT_MODE});

  default clocking cb @(posedge memClk); endclocking
  default disable iff (!reset_n || !memRstN);

  sequence writeBurst_s;
    dc_data_bus_oe [*4] ##1 !dc_data_bus_oe;
  endsequence

  sequence refreshIssue_s;
    ##1 (s.cmd == dcs_pkg::CMD_REFRESH);
  endsequence

  clock_toggle_a: assert property (
    $past(memRstN) |-> dc_write_clock != $past(dc_write_clock))
    else $error("Write clock did not toggle.");

  read_clock_phase_a: assert property (
    dc_read_clock == !dc_write_clock)
    else $error("Read clock lost its phase to the write clock.");

  cmd_edge_a: assert property (
    $changed(s.cmd) |-> !dc_write_clock)
    else $error("Command changed while the memory clock was high.");

  write_burst_a: assert property (
    $rose(isWrite) |-> writeBurst_s)
    else $error("Write burst did not drive exactly two beats.");

  row_map_a: assert property (
    isAct |-> dc_addr_bus == {s.req.addr[10], s.req.addr[11], s.req.addr[21:12]})
    else $error("Row address mapping wrong.");

  col_map_a: assert property (
    $rose(isRead || isWrite) |-> dc_addr_bus == {s.req.addr[10], 3'h0, s.req.addr[9:2]})
    else $error("Column address mapping wrong.");

  mode_word_a: assert property (
    isMode |-> dc_addr_bus[3:0] == 4'h1 && dc_addr_bus[11:7] == 5'h00)
    else $error("Mode word is not burst two sequential.");

  precharge_all_a: assert property (
    isPre |-> dc_addr_bus[dcs_pkg::PRECHARGE_ALL_BIT])
    else $error("Precharge did not select all banks.");

  refresh_first_a: assert property (
    (s.clkPhase && s.state == dcs_pkg::ST_IDLE && s.refDue) |-> refreshIssue_s)
    else $error("Due refresh was not issued first.");

  init_before_access_a: assert property (
    !initDone |-> !isAct && !isRead && !isWrite)
    else $error("Access issued before initialisation finished.");

  oe_write_only_a: assert property (
    $rose(dc_data_bus_oe) |-> isWrite)
    else $error("Data bus driven outside a write.");

endmodule

`default_nettype wire

// ===== verification/dcs_sdram_model.sv
`default_nettype none
// Behavioural pair of 1M x 16 parts side by side: one 32-bit row, two banks.
module dcs_sdram_model (
  input wire logic wClk,
  input wire dcs_pkg::dcs_cmd_type cmd,
  input wire logic [11:0] ma,
  input wire logic [7:0] mask,
  input wire logic [31:0] dq,
  output logic [31:0] dqOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [bit [19:0]];
  logic [10:0] openRow [2];
  logic [11:0] modeVal = '0;
  logic [11:0] actAddr, colAddr;
  logic [7:0] col;
  logic bank;
  logic wrNext = 0;
  logic modeSeen = 0;
  int tick = 0;
  int colTick, preTick, refCnt = 0, preAll = 0, lastRef = 0, maxGap = 0, rdAt = -9;
  initial dqOut = 32'h5A5A_A5A5;
  function automatic logic [19:0] key(input logic [7:0] c);
    return {bank, openRow[bank], c};
  endfunction
  function automatic logic [31:0] fetch(input logic [7:0] c);
    return mem.exists(key(c)) ? mem[key(c)] : 32'hDEAD_BEEF;
  endfunction
  task automatic store(input logic [7:0] c);
    logic [31:0] d;
    d = mem.exists(key(c)) ? mem[key(c)] : 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (!mask[i]) d[8*i+:8] = dq[8*i+:8];
    end
    mem[key(c)] = d;
  endtask
  // Outside a burst the bus toggles every cycle so stale data can never pass as good.
  always @(posedge wClk) begin
    tick++;
    if (wrNext) store(col ^ 8'h01);
    wrNext = 0;
    if (tick == rdAt) dqOut <= #1 fetch(col);
    else if (tick == rdAt + 1) dqOut <= #1 fetch(col ^ 8'h01);
    else dqOut <= #1 ~dqOut;
    case (cmd)
      dcs_pkg::CMD_ACTIVATE: begin
        openRow[ma[11]] = ma[10:0];
        actAddr = ma;
      end
      dcs_pkg::CMD_WRITE, dcs_pkg::CMD_READ: begin
        bank = ma[11];
        col = ma[7:0];
        colAddr = ma;
        colTick = tick;
        if (cmd == dcs_pkg::CMD_WRITE) begin
          store(col);
          wrNext = 1;
        end else rdAt = tick + modeVal[6:4] - 1;
      end
      dcs_pkg::CMD_PRECHARGE: begin
        preTick = tick;
        if (ma[10]) preAll++;
      end
      dcs_pkg::CMD_REFRESH: begin
        if (modeSeen && tick - lastRef > maxGap) maxGap = tick - lastRef;
        lastRef = tick;
        refCnt++;
      end
      dcs_pkg::CMD_MODE: begin
        modeVal = ma;
        modeSeen = 1;
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/dcs_sdram_ctrl_tb.sv
`default_nettype none
module dcs_sdram_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] ADR = 22'h2A_A5C8;
  localparam int MAX_CYCLES = 20000;
  logic sys_clk = 0;
  logic memClk = 0;
  logic reset_n = 0;
  logic reqValid = 0;
  logic rspReady = 0;
  logic sawFull = 0;
  logic reqReady, rspValid, wClk, rClk, oe, csN, rasN, casN, weN;
  dcs_pkg::dcs_req_type reqCmd = '0;
  dcs_pkg::dcs_cfg_type cfg = 5'h1F;
  logic [63:0] rspData, got;
  logic [7:0] mask;
  logic [11:0] ma;
  logic [31:0] dOut, memDq, dq;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  // The offset keeps the link clock edges away from the core clock edges.
  initial begin
    #3.3;
    forever #7.5 memClk = ~memClk;
  end
  assign dq = oe ? dOut : memDq;
  dcs_sdram_ctrl #(.POWERUP_TICKS(20)) dcs_sdram_ctrl_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .memClk(memClk), .reqValid(reqValid),
    .reqReady(reqReady), .reqCmd(reqCmd), .rspValid(rspValid), .rspReady(rspReady),
    .rspData(rspData), .cfg(cfg), .dc_write_clock(wClk), .dc_read_clock(rClk),
    .dc_chip_select_n(csN), .dc_row_strobe_n(rasN), .dc_col_strobe_n(casN),
    .dc_write_enable_n(weN), .dc_byte_mask(mask), .dc_addr_bus(ma),
    .dc_data_bus_out(dOut), .dc_data_bus_oe(oe), .dc_data_bus_in(dq));
  dcs_sdram_model dcs_sdram_model_i (.wClk(wClk), .cmd({csN, rasN, casN, weN}), .ma(ma),
    .mask(mask), .dq(dq), .dqOut(memDq));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (reqValid && reqReady === 1'b0) sawFull <= 1;
    if (cycles == MAX_CYCLES) begin
      err_total++;
      end_sim();
    end
  end
  task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] rowOf(input logic [21:0] a);
    return {a[10], a[11], a[21:12]};
  endfunction
  function automatic logic [11:0] colOf(input logic [21:0] a);
    return {a[10], 3'h0, a[9:2]};
  endfunction
  // Called at a falling edge; leaves the request up so a caller can chain back to back.
  task automatic send(input logic w, input logic [21:0] a, input logic [63:0] d,
                      input logic [7:0] m);
    reqCmd = '{w, a, d, m};
    reqValid = 1;
    do @(posedge sys_clk); while (reqReady !== 1'b1);
    @(negedge sys_clk);
  endtask
  task automatic recv(output logic [63:0] d);
    do @(posedge sys_clk); while (rspValid !== 1'b1);
    d = rspData;
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [21:0] a, input logic [63:0] d, input logic [7:0] m);
    send(1, a, d, m);
    reqValid = 0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [21:0] a);
    send(0, a, 64'h0, 8'h00);
    reqValid = 0;
    recv(got);
  endtask
  task automatic test_init;
    for (int i = 0; i < 3000 && dcs_sdram_model_i.modeSeen !== 1'b1; i++) @(negedge sys_clk);
    check_val(dcs_sdram_model_i.preAll, 1);
    check_val(dcs_sdram_model_i.refCnt, 8);
    check_val(dcs_sdram_model_i.modeVal[2:0], dcs_pkg::BURST_LEN_TWO);
    check_val(dcs_sdram_model_i.modeVal[3], dcs_pkg::WRAP_SEQUENTIAL);
    check_val(rClk, !wClk);
    $display("init done");
  endtask
  task automatic test_rw;
    wr(ADR, 64'hC0DE_0002_ABCD_0001, 8'h00);
    rd(ADR);
    check_val(got, 64'hC0DE_0002_ABCD_0001);
    check_val(dcs_sdram_model_i.actAddr, rowOf(ADR));
    check_val(dcs_sdram_model_i.colAddr, colOf(ADR));
    wr(ADR | 22'h4, 64'h2222_2222_1111_1111, 8'h00);
    rd(ADR);
    check_val(got, 64'h1111_1111_2222_2222);
    wr(ADR, 64'hFFFF_FFFF_FFFF_FFFF, 8'h5A);
    rd(ADR | 22'h4);
    check_val(got, 64'h22FF_22FF_FF11_FF11);
    $display("read write done");
  endtask
  task automatic test_fifo;
    logic [31:0] d;
    rspReady = 0;
    sawFull = 0;
    for (int i = 0; i < 4; i++) begin
      d = 32'hA5A5_0000 + 32'(i);
      send(1, 22'h10_0000 + 22'(i * 8), {~d, d}, 8'h00);
    end
    for (int i = 0; i < 4; i++) send(0, 22'h10_0000 + 22'(i * 8), 64'h0, 8'h00);
    reqValid = 0;
    check_val(sawFull, 1);
    repeat (300) @(negedge sys_clk);
    rspReady = 1;
    for (int i = 0; i < 4; i++) begin
      d = 32'hA5A5_0000 + 32'(i);
      recv(got);
      check_val(got, {~d, d});
    end
    $display("fifo done");
  endtask
  task automatic test_wait;
    int g;
    rd(ADR);
    g = dcs_sdram_model_i.preTick - dcs_sdram_model_i.colTick;
    cfg = 5'h04;
    repeat (10) @(negedge sys_clk);
    rd(ADR);
    check_val(g - (dcs_sdram_model_i.preTick - dcs_sdram_model_i.colTick), 3);
    check_val(got, 64'hFF11_FF11_22FF_22FF);
    $display("wait states done");
  endtask
  task automatic test_refresh;
    int r;
    r = dcs_sdram_model_i.refCnt;
    repeat (1400) @(negedge sys_clk);
    check_val(dcs_sdram_model_i.refCnt > r, 1);
    check_val(dcs_sdram_model_i.maxGap <= dcs_pkg::REFRESH_TICKS + 40, 1);
    $display("refresh done");
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    check_val({csN, rasN, casN, weN, oe, mask}, {dcs_pkg::CMD_NOP, 9'h0});
    reset_n = 1;
    rspReady = 1;
    test_init();
    test_rw();
    test_fifo();
    test_wait();
    test_refresh();
    end_sim();
  end
endmodule
`default_nettype wire
